// [pkg/rxb_pkg.sv]
// Purpose: Shared constants and types for the receive buffer control block.
// Assumes: 8-bit register port, one system clock.
// Notes: Register offsets are byte addresses on the plain register port.
package rxb_pkg;
    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    typedef logic [ADDR_W-1:0] rxb_addr_t;
    typedef logic [DATA_W-1:0] rxb_data_t;

    // Register offsets
    localparam rxb_addr_t OFS_BUF0_CTL = 8'h00;
    localparam rxb_addr_t OFS_BUF1_CTL = 8'h01;
    localparam rxb_addr_t OFS_IRQ_STAT = 8'h02;
    localparam rxb_addr_t OFS_IRQ_MASK = 8'h03;
    localparam rxb_addr_t OFS_OP_MODE = 8'h04;

    // Control register fields
    localparam int BIT_FULL = 7;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_MODE_LO = 5;
    localparam int BIT_RTR_ENH = 5;
    localparam int BIT_UNIMP = 4;
    localparam int BIT_RTR_LEG = 3;
    localparam int BIT_DBEN = 2;
    localparam int BIT_JUMP_TABLE_OFFSET = 1;

    // Interrupt status bits
    localparam int IRQ_BITS = 3;
    localparam int IRQ_RX0 = 0;
    localparam int IRQ_RX1 = 1;
    localparam int IRQ_DROP = 2;

    // Operating modes
    localparam logic [1:0] OPM_LEGACY = 2'h0;
    localparam logic [1:0] OPM_ENH1 = 2'h1;
    localparam logic [1:0] OPM_ENH2 = 2'h2;

    // Receive mode selections, legacy layout
    localparam logic [1:0] RXM_ALL = 2'h3;
    localparam logic [1:0] RXM_EXT = 2'h2;
    localparam logic [1:0] RXM_STD = 2'h1;
    localparam logic [1:0] RXM_FILT = 2'h0;

    // Filters 0 and 1 belong to buffer 0
    localparam logic [4:0] BUF0_FILTERS = 5'h02;

    // Reset values
    localparam logic [1:0] RST_RXM = 2'h0;
    localparam logic [4:0] RST_HIT = 5'h00;
    localparam logic [IRQ_BITS-1:0] RST_IRQ = 3'h0;

    // Frame summary from the protocol engine and filters
    typedef struct packed {
        logic ok;       // Frame received without error
        logic ext;      // Extended identifier frame
        logic rtr;      // Remote transmission request
        logic hit;      // Some acceptance filter matched
        logic [4:0] num; // Number of the matching filter
        logic ext_en;   // Matching filter's extended-id enable
    } rxb_frame_s;
endpackage : rxb_pkg

// [logic/rxb_ctrl.sv]
// Purpose: Buffer-full handshake, receive mode, filter hit and double
//          buffering control for the two dedicated receive buffers.
// Assumes: Frame summary is synchronous and valid for one cycle.
// Notes: Store strobes tell the data path which buffer to load.
`timescale 1ns/1ps

module rxb_ctrl (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Register port
    input wire rxb_pkg::rxb_addr_t reg_addr_i,
    input wire rxb_pkg::rxb_data_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output rxb_pkg::rxb_data_t reg_rdata_o,
    // Frame summary
    input wire logic frame_valid_i,
    input wire rxb_pkg::rxb_frame_s frame_i,
    // Store strobes to the data path
    output logic store0_o,
    output logic store1_o,
    output logic drop_o,
    // Interrupt
    output logic irq_o
);
    import rxb_pkg::*;

    logic full0_r, full1_r;
    logic seen0_r, seen1_r;
    logic [1:0] rx_mode_lo_r, rx_mode_hi_r;
    logic dben_r;
    logic rtr0_r, rtr1_r;
    logic [4:0] hit0_r, hit1_r;
    logic [1:0] opm_r;
    logic [IRQ_BITS-1:0] irq_stat_r, irq_mask_r;
    logic [IRQ_BITS-1:0] irq_stat_nxt;
    rxb_data_t rdata_nxt;
    logic legacy, acc0, acc1, own0, want0, want1, put0, put1, drop;
    logic wr0, wr1, rd0, rd1, clr0, clr1;

    // Acceptance check for one buffer's mode selection
    function automatic logic accept(input logic leg, input logic [1:0] rxm,
                                    input rxb_frame_s f);
        logic res;
        res = 1'b0;
        if (!leg) begin
            res = rxm[1] | (f.ok & f.hit);
        end else begin
            case (rxm)
                RXM_ALL: res = 1'b1;
                RXM_EXT: res = f.ok & f.hit & f.ext;
                RXM_STD: res = f.ok & f.hit & ~f.ext;
                RXM_FILT: res = f.ok & f.hit & (f.ext == f.ext_en);
                default: res = 1'b0;
            endcase
        end
        return res;
    endfunction : accept

    // Address decode
    assign legacy = (opm_r == OPM_LEGACY);
    assign wr0 = reg_wr_i && (reg_addr_i == OFS_BUF0_CTL);
    assign wr1 = reg_wr_i && (reg_addr_i == OFS_BUF1_CTL);
    assign rd0 = reg_rd_i && (reg_addr_i == OFS_BUF0_CTL);
    assign rd1 = reg_rd_i && (reg_addr_i == OFS_BUF1_CTL);
    // Clear of full honoured only once the buffer has been read
    assign clr0 = wr0 && !reg_wdata_i[BIT_FULL] && seen0_r;
    assign clr1 = wr1 && !reg_wdata_i[BIT_FULL] && seen1_r;

    // Steering of an accepted frame
    always_comb begin
        acc0 = accept(legacy, rx_mode_lo_r, frame_i);
        acc1 = accept(legacy, rx_mode_hi_r, frame_i);
        own0 = frame_i.hit && (frame_i.num < BUF0_FILTERS);
        want0 = frame_valid_i && acc0 && (own0 || (rx_mode_lo_r[1] && !frame_i.hit));
        // Filters 0 and 1 never reach buffer 1 directly
        want1 = frame_valid_i && acc1 && !own0;
        put0 = want0 && !full0_r;
        // Overflow only in legacy mode with double buffering on
        put1 = !put0 && !full1_r &&
               ((want0 && legacy && dben_r) || want1);
        drop = (want0 || want1) && !put0 && !put1;
    end

    // Store strobes, one cycle after the frame
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            store0_o <= 1'b0;
            store1_o <= 1'b0;
            drop_o <= 1'b0;
        end else begin
            store0_o <= put0;
            store1_o <= put1;
            drop_o <= drop;
        end
    end

    // Full flags; a store can meet a clear once the flag is already low, and the store wins
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            full0_r <= 1'b0;
            full1_r <= 1'b0;
        end else begin
            if (put0) begin
                full0_r <= 1'b1;
            end else if (clr0) begin
                full0_r <= 1'b0;
            end
            if (put1) begin
                full1_r <= 1'b1;
            end else if (clr1) begin
                full1_r <= 1'b0;
            end
        end
    end

    // Read-seen markers, restarted by each new store
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            seen0_r <= 1'b0;
            seen1_r <= 1'b0;
        end else begin
            if (put0) begin
                seen0_r <= 1'b0;
            end else if (rd0 && full0_r) begin
                seen0_r <= 1'b1;
            end
            if (put1) begin
                seen1_r <= 1'b0;
            end else if (rd1 && full1_r) begin
                seen1_r <= 1'b1;
            end
        end
    end

    // Frame attributes captured with the full flag
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rtr0_r <= 1'b0;
            rtr1_r <= 1'b0;
            hit0_r <= RST_HIT;
            hit1_r <= RST_HIT;
        end else begin
            if (put0) begin
                rtr0_r <= frame_i.rtr;
                hit0_r <= frame_i.num;
            end
            if (put1) begin
                rtr1_r <= frame_i.rtr;
                hit1_r <= frame_i.num;
            end
        end
    end

    // Software-written controls
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_mode_lo_r <= RST_RXM;
            rx_mode_hi_r <= RST_RXM;
            dben_r <= 1'b0;
            opm_r <= OPM_LEGACY;
            irq_mask_r <= RST_IRQ;
        end else begin
            if (wr0) begin
                rx_mode_lo_r[1] <= reg_wdata_i[BIT_MODE_HI];
                // Lower mode bit is the remote flag in enhanced modes
                if (legacy) begin
                    rx_mode_lo_r[0] <= reg_wdata_i[BIT_MODE_LO];
                    dben_r <= reg_wdata_i[BIT_DBEN];
                end
            end
            if (wr1) begin
                rx_mode_hi_r[1] <= reg_wdata_i[BIT_MODE_HI];
                if (legacy) begin
                    rx_mode_hi_r[0] <= reg_wdata_i[BIT_MODE_LO];
                end
            end
            // Code 3 is not a mode and is ignored
            if (reg_wr_i && reg_addr_i == OFS_OP_MODE &&
                reg_wdata_i[1:0] != 2'h3) begin
                opm_r <= reg_wdata_i[1:0];
            end
            if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK) begin
                irq_mask_r <= reg_wdata_i[IRQ_BITS-1:0];
            end
        end
    end

    // Interrupt status: set beats write-one-to-clear
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (reg_wr_i && reg_addr_i == OFS_IRQ_STAT) begin
            irq_stat_nxt = irq_stat_r & ~reg_wdata_i[IRQ_BITS-1:0];
        end
        // Buffer 0 flag cannot stay clear while the buffer is full
        if (put0 || full0_r) begin
            irq_stat_nxt[IRQ_RX0] = 1'b1;
        end
        if (put1) begin
            irq_stat_nxt[IRQ_RX1] = 1'b1;
        end
        if (drop) begin
            irq_stat_nxt[IRQ_DROP] = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            irq_stat_r <= RST_IRQ;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // Read data mux, layouts differ per mode
    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_addr_i)
            OFS_BUF0_CTL: begin
                if (legacy) begin
                    // Jump-table bit mirrors the enable for a shared table
                    rdata_nxt = {full0_r, rx_mode_lo_r, 1'b0, rtr0_r,
                                 dben_r, dben_r, hit0_r[0]};
                end else begin
                    rdata_nxt = {full0_r, rx_mode_lo_r[1], rtr0_r, hit0_r};
                end
            end
            OFS_BUF1_CTL: begin
                if (legacy) begin
                    rdata_nxt = {full1_r, rx_mode_hi_r, 1'b0, rtr1_r,
                                 hit1_r[2:0]};
                end else begin
                    rdata_nxt = {full1_r, rx_mode_hi_r[1], rtr1_r, hit1_r};
                end
            end
            OFS_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
            OFS_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
            OFS_OP_MODE: rdata_nxt = {6'h00, opm_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Checks
    sequence s_store0;
        put0 ##1 (full0_r && store0_o);
    endsequence

    sequence s_store1;
        put1 ##1 (full1_r && store1_o);
    endsequence

    full_set_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        put0 |-> s_store0)
        else $error("buffer 0 full flag not set on store");

    no_load_full_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        full1_r |=> !store1_o)
        else $error("full buffer 1 was loaded");

    irq_again_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        full0_r |=> irq_stat_r[IRQ_RX0])
        else $error("buffer 0 interrupt flag clear while full");

    open_take_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (want0 && !full0_r) |-> s_store0)
        else $error("open buffer 0 refused an accepted frame");

    no_overflow_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (legacy && !dben_r && frame_valid_i && own0) |=> !store1_o)
        else $error("overflow into buffer 1 with double buffering off");

    overflow_drop_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (want0 && full0_r && full1_r) |=> (drop_o && !store1_o))
        else $error("overflow with buffer 1 full was not dropped");

    jump_table_offset_copy_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rd0 && legacy) |=> (reg_rdata_o[BIT_JUMP_TABLE_OFFSET] == reg_rdata_o[BIT_DBEN]))
        else $error("jump table bit differs from enable");

    unimp_zero_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rd0 && legacy) |=> !reg_rdata_o[BIT_UNIMP])
        else $error("unimplemented bit read as one");

    hit_capture_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_store1 |-> (hit1_r == $past(frame_i.num) && rtr1_r == $past(frame_i.rtr)))
        else $error("buffer 1 attributes not captured with full flag");

    low_filter_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (legacy && put1 && own0) |-> dben_r)
        else $error("filter 0 or 1 reached buffer 1 without double buffering");

    rtr_pos_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rd0 && !legacy) |=> (reg_rdata_o[BIT_RTR_ENH] == $past(rtr0_r)))
        else $error("enhanced remote flag misplaced");

    // A frame has one destination at most, so strobes never overlap
    strobe_onehot_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $onehot0({store0_o, store1_o, drop_o}))
        else $error("more than one store strobe at once");

    clear_read0_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $fell(full0_r) |-> $past(clr0))
        else $error("buffer 0 full flag dropped without a read and clear");

    clear_read1_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $fell(full1_r) |-> $past(clr1))
        else $error("buffer 1 full flag dropped without a read and clear");

    no_load0_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        full0_r |=> !store0_o)
        else $error("full buffer 0 was loaded");

    hit0_capture_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_store0 |-> (hit0_r == $past(frame_i.num) && rtr0_r == $past(frame_i.rtr)))
        else $error("buffer 0 attributes not captured with full flag");

    full_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        rd0 |=> (reg_rdata_o[BIT_FULL] == $past(full0_r)))
        else $error("buffer 0 full flag misread");

    leg_hit0_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rd0 && legacy) |=> (reg_rdata_o[0] == $past(hit0_r[0])))
        else $error("legacy buffer 0 filter hit bit misread");

    enh_hit0_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rd0 && !legacy) |=> (reg_rdata_o[4:0] == $past(hit0_r)))
        else $error("enhanced buffer 0 filter hit code misread");

    leg_hit1_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rd1 && legacy) |=> (reg_rdata_o[2:0] == $past(hit1_r[2:0])))
        else $error("legacy buffer 1 filter hit field misread");

    leg_rtr1_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rd1 && legacy) |=> (reg_rdata_o[BIT_RTR_LEG] == $past(rtr1_r)))
        else $error("legacy buffer 1 remote flag misplaced");

    ext_only_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (legacy && !dben_r && frame_valid_i && rx_mode_hi_r == RXM_EXT && !frame_i.ext)
        |=> !store1_o)
        else $error("standard frame stored in extended-only buffer 1");

    enh_all_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (!legacy && frame_valid_i && rx_mode_hi_r[1] && frame_i.hit && !own0 && !full1_r)
        |=> store1_o)
        else $error("receive-all buffer 1 refused a frame");
endmodule : rxb_ctrl

// [tb/rxb_frame_src.sv]
// Purpose: Frame source standing in for the protocol engine and filters.
// Assumes: One frame summary per send request, valid for one cycle.
// Notes: Idle summary toggles every cycle so stale fields never look valid.
`timescale 1ns/1ps
module rxb_frame_src (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Request from the bench
    input wire logic send_i,
    input wire rxb_pkg::rxb_frame_s frame_i,
    // Summary toward the block
    output logic frame_valid_o,
    output rxb_pkg::rxb_frame_s frame_o
);
    import rxb_pkg::*;
    // One-cycle valid; fields scrambled outside it, no kinder than a real engine
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            frame_valid_o <= 1'b0;
            frame_o <= '0;
        end else begin
            frame_valid_o <= send_i;
            frame_o <= send_i ? frame_i : ~frame_o;
        end
    end
endmodule : rxb_frame_src

// [tb/tb.sv]
// Purpose: Self-checking bench for the receive buffer control block.
// Assumes: Legacy mode after reset, register reads answer one cycle later.
// Notes: Expected results queue up; a monitor pops them as results appear.
`timescale 1ns/1ps
module tb;
    import rxb_pkg::*;
    logic clock_i, sys_rst_i, reg_wr_i, reg_rd_i, frame_valid_i;
    logic send, mon_on, rd_d, fv_d, acc;
    logic store0_o, store1_o, drop_o, irq_o;
    logic [1:0] m;
    rxb_addr_t reg_addr_i;
    rxb_data_t reg_wdata_i, reg_rdata_o;
    rxb_frame_s frame_i, fin, f;
    rxb_data_t rd_q[$];
    rxb_data_t st_q[$];
    int err_total, checks;

    rxb_ctrl rxb_ctrl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
        .store0_o(store0_o), .store1_o(store1_o), .drop_o(drop_o), .irq_o(irq_o));
    rxb_frame_src rxb_frame_src_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .send_i(send),
        .frame_i(fin), .frame_valid_o(frame_valid_i), .frame_o(frame_i));

    // 100 ns clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic chk(input string nm, input rxb_data_t e, input rxb_data_t g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input rxb_addr_t a, input rxb_data_t d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input rxb_addr_t a, input rxb_data_t e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        rd_q.push_back(e);
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
    endtask : rd

    task automatic fr(input rxb_frame_s x, input logic [2:0] e);
        @(posedge clock_i);
        fin <= x;
        send <= 1'b1;
        st_q.push_back({5'h00, e});
        @(posedge clock_i);
        send <= 1'b0;
    endtask : fr

    // Irq is combinational, so look at it mid-cycle
    task automatic ichk(input logic e);
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        chk("irq", {7'h00, e}, {7'h00, irq_o});
    endtask : ichk

    // Flags are {ok, ext, rtr, hit}
    function automatic rxb_frame_s mk(input logic [3:0] fl, input logic [4:0] n, input logic een);
        mk = {fl, n, een};
    endfunction : mk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Results pair with the oldest note; strobes must be quiet between frames
    always @(posedge clock_i) begin
        if (mon_on && rd_d) chk("read data", rd_q.pop_front(), reg_rdata_o);
        if (mon_on) chk("strobes", fv_d ? st_q.pop_front() : 8'h00,
            {5'h00, store0_o, store1_o, drop_o});
        rd_d <= reg_rd_i;
        fv_d <= frame_valid_i;
    end

    // Whole run is under 500 cycles; cut a hang well past that
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        err_total = 0;
        checks = 0;
        sys_rst_i = 1'b1;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        send = 1'b0;
        fin = '0;
        mon_on = 1'b0;
        rd_d = 1'b0;
        fv_d = 1'b0;
        void'($urandom(32'h2E8A));
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        mon_on <= 1'b1;
        for (int a = 0; a < 6; a++) rd(rxb_addr_t'(a), 8'h00);
        ichk(1'b0);
        $display("test reset values done");
        wr(OFS_IRQ_MASK, 8'h07);
        fr(mk(4'hB, 5'h01, 1'b0), 3'b100);
        wr(OFS_BUF0_CTL, 8'h00);
        rd(OFS_BUF0_CTL, 8'h89);
        fr(mk(4'h9, 5'h00, 1'b0), 3'b001);
        rd(OFS_BUF0_CTL, 8'h89);
        wr(OFS_IRQ_STAT, 8'h01);
        rd(OFS_IRQ_STAT, 8'h05);
        ichk(1'b1);
        wr(OFS_IRQ_MASK, 8'h00);
        ichk(1'b0);
        wr(OFS_IRQ_MASK, 8'h07);
        wr(OFS_BUF0_CTL, 8'h00);
        wr(OFS_IRQ_STAT, 8'h07);
        rd(OFS_IRQ_STAT, 8'h00);
        ichk(1'b0);
        $display("test full handshake done");
        wr(OFS_BUF0_CTL, 8'h14);
        fr(mk(4'h9, 5'h00, 1'b0), 3'b100);
        rd(OFS_BUF0_CTL, 8'h86);
        fr(mk(4'hB, 5'h01, 1'b0), 3'b010);
        fr(mk(4'h9, 5'h00, 1'b0), 3'b001);
        rd(OFS_BUF1_CTL, 8'h89);
        rd(OFS_BUF0_CTL, 8'h86);
        wr(OFS_BUF0_CTL, 8'h00);
        wr(OFS_BUF1_CTL, 8'h00);
        $display("test double buffering done");
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            wr(OFS_BUF1_CTL, {1'b0, m, 5'h00});
            repeat (8) begin
                f = rxb_frame_s'(10'($urandom));
                f.num = 5'(2 + $urandom % 4);
                acc = (m == RXM_ALL) || (f.ok && f.hit && ((m == RXM_EXT) ? f.ext :
                    (m == RXM_STD) ? !f.ext : (f.ext == f.ext_en)));
                fr(f, {1'b0, acc, 1'b0});
                if (acc) begin
                    rd(OFS_BUF1_CTL, {1'b1, m, 1'b0, f.rtr, f.num[2:0]});
                    wr(OFS_BUF1_CTL, {1'b0, m, 5'h00});
                end
            end
        end
        $display("test legacy modes done");
        for (int op = 1; op < 3; op++) begin
            wr(OFS_OP_MODE, 8'(op));
            wr(OFS_OP_MODE, 8'h03);
            rd(OFS_OP_MODE, 8'(op));
            for (int h = 0; h < 2; h++) begin
                wr(OFS_BUF1_CTL, {1'b0, 1'(h), 6'h00});
                repeat (6) begin
                    f = rxb_frame_s'(10'($urandom));
                    f.num = 5'(2 + $urandom % 14);
                    acc = (h == 1) || (f.ok && f.hit);
                    fr(f, {1'b0, acc, 1'b0});
                    if (acc) begin
                        rd(OFS_BUF1_CTL, {1'b1, 1'(h), f.rtr, f.num});
                        wr(OFS_BUF1_CTL, {1'b0, 1'(h), 6'h00});
                    end
                end
            end
        end
        // Buffer 0 in enhanced layout: filter 1 frame, remote flag at bit 5
        fr(mk(4'hB, 5'h01, 1'b0), 3'b100);
        rd(OFS_BUF0_CTL, 8'hA1);
        $display("test enhanced modes done");
        // Last notes are compared up to two edges after the final request
        repeat (3) @(posedge clock_i);
        chk("pending notes", 8'h00, 8'(rd_q.size() + st_q.size()));
        report_and_stop();
    end
endmodule : tb
